// ---- hdl/slave_node_ctrl.v ----
// Slave-node mode control of a single-wire clock-extension bus transceiver.
// Assumes host UART on txd/rxd, AXI4-Lite for control, bus wired externally.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "slave_node_consts.vh"
module slave_node_ctrl #(
    parameter MODE_CHANGE_CYCLES = `MODE_CHANGE_CYCLES,
    parameter TX_SHORTEN_CYCLES = `TX_PULSE_SHORTEN_CYCLES,
    parameter BAUD_DIV = `BAUD_DIV_DEFAULT
) (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire role_select,
    input wire sleep_ctrl_n,
    input wire txd,
    output reg rxd_o,
    output reg rxd_oe,
    output reg clk_o,
    output reg clk_oe,
    input wire bus_i,
    output reg bus_o,
    output reg bus_oe
);
    wire [2:0] pins_s;
    wire role_s = pins_s[0];
    wire sleep_ctrl_n_s = pins_s[1];
    wire txd_s = pins_s[2];
    wire bus_s;
    reg [3:0] mode_r;
    reg [31:0] mc_cnt_r;
    reg sleep_ctrl_n_d_r, txd_d_r;
    reg [3:0] ctrl_r;
    reg drv_en_r, ot_seen_r;
    reg [15:0] baud_r;
    reg [15:0] bdiv_r;
    reg bclk_r;
    reg [31:0] low_cnt_r;
    reg wake_tx_r;
    reg bus_d_r;
    reg [31:0] bus_low_r;
    // Receive path: bus bit sampler then UART frame out
    reg [3:0] rx_bit_r;
    reg [7:0] rx_sh_r;
    reg [7:0] rx_byte_r;
    reg rx_valid_r;
    reg [3:0] tx_bit_r;
    reg [9:0] tx_fr_r;
    reg bclk_d_r;
    // Sample late in the high phase, as the bus is pulled low while the clock is low
    wire bclk_fall = ~bclk_r & bclk_d_r;
    wire rd_rx;
    wire sleep_ctrl_n_fall = sleep_ctrl_n_d_r & ~sleep_ctrl_n_s;
    wire sleep_ctrl_n_rise = ~sleep_ctrl_n_d_r & sleep_ctrl_n_s;
    wire txd_edge = txd_d_r ^ txd_s;

    // Sleep control starts low, so no false rising edge after reset
    pin_sync #(.WIDTH(4), .INIT(4'hD)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({bus_i, txd, sleep_ctrl_n, role_select}),
        .dout({bus_s, pins_s})
    );

    // Bus wake pulse detect: low for the mode-change time
    wire bus_wake = (bus_low_r >= MODE_CHANGE_CYCLES);
    wire wake_cause = ctrl_r[`CTRL_LOCAL_WAKE] | bus_wake;

    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= `MODE_SLEEP;
            mc_cnt_r <= 32'h00000000;
        end else begin
            case (mode_r)
                `MODE_SLEEP: begin
                    mc_cnt_r <= 32'h00000000;
                    // host low on txd starts pulse
                    if (!sleep_ctrl_n_s && !txd_s && role_s) begin
                        mode_r <= `MODE_WAKE;
                    end else if (wake_cause || sleep_ctrl_n_rise) begin
                        mode_r <= `MODE_STANDBY;
                    end
                end
                `MODE_WAKE: begin
                    if (txd_s || sleep_ctrl_n_s) begin
                        mode_r <= `MODE_SLEEP;
                    end
                end
                `MODE_STANDBY: begin
                    if (ctrl_r[`CTRL_BUS_ERROR]) begin
                        mode_r <= `MODE_SLEEP;
                    end else if (mc_cnt_r >= MODE_CHANGE_CYCLES - 1) begin
                        mode_r <= `MODE_NORMAL;
                        mc_cnt_r <= 32'h00000000;
                    end else begin
                        mc_cnt_r <= mc_cnt_r + 32'h00000001;
                    end
                end
                `MODE_NORMAL: begin
                    if (sleep_ctrl_n_fall || !sleep_ctrl_n_s || ctrl_r[`CTRL_BUS_ERROR]
                        || ctrl_r[`CTRL_SLEEP_DONE]) begin
                        mode_r <= `MODE_SLEEP;
                    end
                end
                default: mode_r <= `MODE_SLEEP;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            sleep_ctrl_n_d_r <= 1'b0;
            txd_d_r <= 1'b1;
            bus_d_r <= 1'b1;
            bus_low_r <= 32'h00000000;
            low_cnt_r <= 32'h00000000;
            wake_tx_r <= 1'b1;
            drv_en_r <= 1'b1;
            ot_seen_r <= 1'b0;
        end else begin
            sleep_ctrl_n_d_r <= sleep_ctrl_n_s;
            txd_d_r <= txd_s;
            bus_d_r <= bus_s;
            bus_low_r <= bus_s ? 32'h00000000 : bus_low_r + 32'h00000001;
            // pulse is txd low minus shortening
            if (mode_r == `MODE_WAKE && !txd_s) begin
                low_cnt_r <= low_cnt_r + 32'h00000001;
                wake_tx_r <= (low_cnt_r >= TX_SHORTEN_CYCLES - 1) ? 1'b0 : 1'b1;
            end else begin
                low_cnt_r <= 32'h00000000;
                wake_tx_r <= 1'b1;
            end
            // overtemp off, back on at txd toggle
            if (ctrl_r[`CTRL_OVERTEMP]) begin
                drv_en_r <= 1'b0;
                ot_seen_r <= 1'b1;
            end else if (ot_seen_r && txd_edge) begin
                drv_en_r <= 1'b1;
                ot_seen_r <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            bdiv_r <= 16'h0000;
            bclk_r <= 1'b1;
            bclk_d_r <= 1'b1;
        end else begin
            bclk_d_r <= bclk_r;
            if (bdiv_r >= baud_r - 16'h0001) begin
                bdiv_r <= 16'h0000;
                bclk_r <= ~bclk_r;
            end else begin
                bdiv_r <= bdiv_r + 16'h0001;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_byte_r <= 8'h00;
            rx_valid_r <= 1'b0;
            tx_bit_r <= 4'h0;
            tx_fr_r <= 10'h3FF;
        end else if (mode_r != `MODE_NORMAL) begin
            if (rd_rx) rx_valid_r <= 1'b0;
            rx_bit_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_fr_r <= 10'h3FF;
        end else if (bclk_fall) begin
            // A read clears, a new byte in the same cycle wins
            if (rd_rx) rx_valid_r <= 1'b0;
            if (rx_bit_r == 4'h0) begin
                if (!bus_s) rx_bit_r <= 4'h1;
            end else if (rx_bit_r < 4'h9) begin
                rx_sh_r <= {bus_s, rx_sh_r[7:1]};
                rx_bit_r <= rx_bit_r + 4'h1;
            end else begin
                rx_bit_r <= 4'h0;
                rx_byte_r <= rx_sh_r;
                rx_valid_r <= 1'b1;
                tx_fr_r <= {1'b1, rx_sh_r, 1'b0};
                tx_bit_r <= 4'hA;
            end
            if (tx_bit_r != 4'h0 && rx_bit_r != 4'h9) begin
                tx_fr_r <= {1'b1, tx_fr_r[9:1]};
                tx_bit_r <= tx_bit_r - 4'h1;
            end
        end else if (rd_rx) begin
            rx_valid_r <= 1'b0;
        end
    end

    // Pin drive per mode
    always @* begin
        clk_o = 1'b1;
        clk_oe = 1'b0;
        rxd_o = 1'b1;
        rxd_oe = 1'b0;
        bus_o = 1'b1;
        bus_oe = 1'b0;
        if (role_s) begin
            case (mode_r)
                `MODE_SLEEP: begin
                    clk_o = bus_s;
                    clk_oe = 1'b1;
                    rxd_o = 1'b1;
                    rxd_oe = 1'b1;
                end
                `MODE_WAKE: begin
                    bus_o = wake_tx_r;
                    bus_oe = drv_en_r & ~wake_tx_r;
                    rxd_oe = 1'b1;
                end
                `MODE_NORMAL: begin
                    clk_o = bclk_r;
                    clk_oe = 1'b1;
                    rxd_o = tx_fr_r[0];
                    rxd_oe = 1'b1;
                    // driver off as soon as sleep_ctrl_n drops
                    bus_o = txd_s | bclk_r;
                    bus_oe = drv_en_r & sleep_ctrl_n_s & ~bus_o;
                end
                `MODE_STANDBY: clk_oe = 1'b0;
                default: clk_oe = 1'b0;
            endcase
        end
    end

    // AXI4-Lite slave: one write and one read at a time
    reg aw_got_r, w_got_r;
    reg [3:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_rx = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `ADDR_RXDATA);
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            ctrl_r <= 4'h0;
            baud_r <= BAUD_DIV[15:0];
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (aw_got_r && w_got_r) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                if (aw_addr_r == `ADDR_CTRL) begin
                    if (w_strb_r[0]) ctrl_r <= w_data_r[3:0];
                end else if (aw_addr_r == `ADDR_BAUD) begin
                    if (w_strb_r[0]) baud_r[7:0] <= w_data_r[7:0];
                    if (w_strb_r[1]) baud_r[15:8] <= w_data_r[15:8];
                end else if (aw_addr_r != `ADDR_STATUS && aw_addr_r != `ADDR_RXDATA) begin
                    s_axi_bresp <= `RESP_DECERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_CTRL: s_axi_rdata <= {28'h0000000, ctrl_r};
                    `ADDR_STATUS: s_axi_rdata <= {25'h0000000, rx_valid_r, drv_en_r,
                        role_s, mode_r};
                    `ADDR_RXDATA: s_axi_rdata <= {24'h000000, rx_byte_r};
                    `ADDR_BAUD: s_axi_rdata <= {16'h0000, baud_r};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_DECERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // slave_node_ctrl
`default_nettype wire

// ---- hdl/slave_node_consts.vh ----
// Shared constants for the slave-node mode control block.
// Assumes a 100 MHz aclk; times are converted to cycles here.
`ifndef SLAVE_NODE_CONSTS_VH
`define SLAVE_NODE_CONSTS_VH
`define CLK_PERIOD_NS 10
`define MODE_CHANGE_TIME_NS 200000
`define MODE_CHANGE_CYCLES (`MODE_CHANGE_TIME_NS / `CLK_PERIOD_NS)
`define TX_PULSE_SHORTEN_NS 66000
`define TX_PULSE_SHORTEN_CYCLES (`TX_PULSE_SHORTEN_NS / `CLK_PERIOD_NS)
`define BAUD_DIV_DEFAULT 2500
`define MODE_SLEEP 4'h1
`define MODE_STANDBY 4'h2
`define MODE_NORMAL 4'h4
`define MODE_WAKE 4'h8
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_RXDATA 4'h8
`define ADDR_BAUD 4'hC
`define CTRL_LOCAL_WAKE 0
`define CTRL_BUS_ERROR 1
`define CTRL_SLEEP_DONE 2
`define CTRL_OVERTEMP 3
`define STAT_MODE_LSB 0
`define STAT_ROLE 4
`define STAT_DRV_EN 5
`define STAT_RX_VALID 6
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ---- hdl/pin_sync.v ----
// Three-stage synchroniser for asynchronous pins with agree filter.
// Assumes the pin is slower than aclk; output changes when stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    genvar i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_agree
            always @(posedge aclk) begin
                if (!aresetn) begin
                    dout[i] <= INIT[i];
                end else if (s2_r[i] == s3_r[i]) begin
                    dout[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

// ---- bench/slave_node_chk.sv ----
// Assertion checker for the slave-node mode control block.
// Assumes it is bound to slave_node_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module slave_node_chk #(
    parameter MODE_CHANGE_CYCLES = 20,
    parameter TX_SHORTEN_CYCLES = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic role_select,
    input wire logic sleep_ctrl_n,
    input wire logic txd,
    input wire logic bus_i,
    input wire logic rxd_o,
    input wire logic rxd_oe,
    input wire logic clk_oe,
    input wire logic bus_oe
);
    localparam int MC_LO = MODE_CHANGE_CYCLES;
    localparam int MC_HI = MODE_CHANGE_CYCLES + 12;
    reg [7:0] slp_cnt_r;
    reg [7:0] txl_cnt_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Saturating timers, so a long quiet sleep never wraps
    always @(posedge aclk) begin
        if (!aresetn || sleep_ctrl_n || !txd || !bus_i || !role_select)
            slp_cnt_r <= 8'h00;
        else if (slp_cnt_r != 8'hC8)
            slp_cnt_r <= slp_cnt_r + 8'h01;
        if (!aresetn || sleep_ctrl_n || txd)
            txl_cnt_r <= 8'h00;
        else if (txl_cnt_r != 8'hFF)
            txl_cnt_r <= txl_cnt_r + 8'h01;
    end
    chk_sleep_rxd_high: assert property (slp_cnt_r == 8'hC8 |-> rxd_oe && rxd_o)
        else $error("rxd not held high in sleep");
    chk_pulse_shortened: assert property (txl_cnt_r != 8'h00 && txl_cnt_r <= TX_SHORTEN_CYCLES |-> !bus_oe)
        else $error("wake pulse not shortened");
    chk_pulse_driven: assert property (txl_cnt_r == TX_SHORTEN_CYCLES + 6 |-> bus_oe)
        else $error("wake pulse not driven");
    chk_sleep_tx_off: assert property ((!sleep_ctrl_n && txd) [*8] |-> !bus_oe)
        else $error("bus driven in sleep");
    chk_wake_hiz: assert property ($rose(sleep_ctrl_n) ##6 1'b1 |-> (!bus_oe && !rxd_oe && !clk_oe) [*8])
        else $error("pins driven during mode change");
    chk_normal_clock: assert property ($rose(sleep_ctrl_n) && role_select |-> ##[MC_LO:MC_HI] clk_oe)
        else $error("clock pin not driven after mode change");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");
endmodule // slave_node_chk
bind slave_node_ctrl slave_node_chk #(.MODE_CHANGE_CYCLES(MODE_CHANGE_CYCLES),
    .TX_SHORTEN_CYCLES(TX_SHORTEN_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .role_select(role_select),
    .sleep_ctrl_n(sleep_ctrl_n), .txd(txd), .bus_i(bus_i), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
    .clk_oe(clk_oe), .bus_oe(bus_oe));
`default_nettype wire

// ---- bench/cxpi_far_node.sv ----
// Far-side model: bus pull-up, other nodes' pulses and master clock bursts.
// Assumes the block's open-drain bus enable and the clock pin level.
`timescale 1ns/10ps
`default_nettype none
module cxpi_far_node (
    input wire logic clk_pin,
    input wire logic bus_o,
    input wire logic bus_oe,
    output wire logic bus_i
);
    logic pull_n = 1'h1;
    // Pull-up, so a released bus reads high
    assign bus_i = pull_n & ~(bus_oe & ~bus_o);
    task automatic pulse_low(input int ns);
        #2 pull_n = 1'h0;
        #(ns) pull_n = 1'h1;
    endtask
    // Stands high between bursts
    task automatic burst_clock(input int n);
        repeat (n) begin
            pull_n = 1'h0;
            #40 pull_n = 1'h1;
            #40;
        end
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_pin);
            pull_n = f[i];
        end
        @(negedge clk_pin);
        pull_n = 1'h1;
    endtask
endmodule // cxpi_far_node
`default_nettype wire

// ---- bench/slave_node_ctrl_tb.sv ----
// Self-checking bench for the slave-node mode control block.
// Assumes short mode-change and pulse-shortening counts set below.
`timescale 1ns/10ps
`default_nettype none
module slave_node_ctrl_tb;
    localparam int MC = 20;
    localparam int TXS = 5;
    localparam int TXL = 15;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    // powered up with sleep control low
    logic sleep_ctrl_n = 1'h0, txd = 1'h1;
    // role only changed while in Sleep
    logic role_select = 1'h1;
    wire awready, wready, bvalid, arready, rvalid, rxd_o, rxd_oe, clk_o, clk_oe;
    wire bus_i, bus_o, bus_oe;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire clk_pin = clk_oe ? clk_o : 1'h1;
    int num_errors = 0, checked = 0, rises = 0, drv = 0;
    logic [31:0] rd;
    logic [1:0] rr;
    always #5 aclk = ~aclk;
    always @(posedge clk_pin) rises++;
    always @(posedge aclk) if (bus_oe) drv++;
    slave_node_ctrl #(.MODE_CHANGE_CYCLES(MC), .TX_SHORTEN_CYCLES(TXS)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .role_select(role_select), .sleep_ctrl_n(sleep_ctrl_n), .txd(txd), .rxd_o(rxd_o),
        .rxd_oe(rxd_oe), .clk_o(clk_o), .clk_oe(clk_oe), .bus_i(bus_i), .bus_o(bus_o),
        .bus_oe(bus_oe));
    cxpi_far_node u_node (.clk_pin(clk_pin), .bus_o(bus_o), .bus_oe(bus_oe), .bus_i(bus_i));
    task automatic end_of_test;
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid && n < 50);
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid && n < 50);
        rd = rdata;
        rr = rresp;
        rready <= 1'h0;
    endtask
    task automatic t_reset_state;
        axi_rd(4'h4);
        check("mode and role", rd[4:0], 32'h11);
        axi_rd(4'h6);
        check("unmapped resp", rr, 32'h3);
        check("unmapped data", rd, 32'h0);
    endtask
    task automatic t_sleep_clock;
        int n = rises;
        #3;
        u_node.burst_clock(6);
        cyc(8);
        check("clk pin edges", rises - n, 32'h6);
        check("rxd pin", {rxd_oe, rxd_o}, 32'h3);
    endtask
    // host holds txd low longer than the shortening
    task automatic t_wake_pulse;
        drv = 0;
        txd <= 1'h0;
        cyc(TXL);
        txd <= 1'h1;
        cyc(10);
        check("pulse width", drv >= TXL - TXS - 1 && drv <= TXL - TXS + 1, 32'h1);
    endtask
    task automatic t_wake_up;
        longint t;
        axi_wr(4'hC, 32'h8);
        sleep_ctrl_n <= 1'h1;
        cyc(8);
        axi_rd(4'h4);
        check("standby", rd[3:0], 32'h2);
        check("pins released", {bus_oe, rxd_oe, clk_oe}, 32'h0);
        cyc(MC + 10);
        axi_rd(4'h4);
        check("normal", rd[3:0], 32'h4);
        @(posedge clk_pin);
        t = $time;
        @(posedge clk_pin);
        check("clk period", 32'(($time - t) / 10), 32'h10);
    endtask
    task automatic t_receive;
        u_node.send_byte(8'h3A);
        cyc(40);
        axi_rd(4'h8);
        check("rx byte", rd[7:0], 32'h3A);
        axi_rd(4'h4);
        check("rx valid cleared", rd[6], 32'h0);
    endtask
    task automatic t_overtemp;
        axi_wr(4'h0, 32'h8);
        axi_wr(4'h0, 32'h0);
        axi_rd(4'h4);
        check("driver held off", rd[5], 32'h0);
        txd <= 1'h0;
        cyc(6);
        txd <= 1'h1;
        cyc(6);
        axi_rd(4'h4);
        check("driver back", rd[5], 32'h1);
    endtask
    task automatic t_error_and_local;
        axi_wr(4'h0, 32'h2);
        axi_rd(4'h4);
        check("sleep on error", rd[3:0], 32'h1);
        axi_wr(4'h0, 32'h1);
        cyc(2 * MC + 20);
        axi_rd(4'h4);
        check("local wake", rd[3:0], 32'h4);
        axi_wr(4'h0, 32'h0);
    endtask
    // sleep requested with txd already high
    task automatic t_sleep_entry;
        sleep_ctrl_n <= 1'h0;
        cyc(8);
        check("bus released", bus_oe, 32'h0);
        axi_rd(4'h4);
        check("sleep", rd[3:0], 32'h1);
        u_node.pulse_low(10 * (MC + 10));
        axi_rd(4'h4);
        check("bus wake", rd[3:0], 32'h2);
    endtask
    task automatic t_role_low;
        cyc(100);
        role_select <= 1'h0;
        cyc(8);
        check("pins off as master", {clk_oe, rxd_oe, bus_oe}, 32'h0);
        role_select <= 1'h1;
        cyc(8);
        check("clock pin back", clk_oe, 32'h1);
    endtask
    initial begin
        cyc(5);
        aresetn <= 1'h1;
        cyc(10);
        t_reset_state;
        t_sleep_clock;
        t_wake_pulse;
        t_wake_up;
        t_receive;
        t_overtemp;
        t_error_and_local;
        t_sleep_entry;
        t_role_low;
        cyc(300);
        end_of_test;
    end
    // Whole run is about a thousand cycles
    initial begin
        #100000;
        num_errors++;
        end_of_test;
    end
endmodule // slave_node_ctrl_tb
`default_nettype wire
